/* twug_consts.svh */
`ifndef TWUG_CONSTS_SVH
`define TWUG_CONSTS_SVH

// Register addresses in the special-function space
`define TWUG_ADDR_KEY 8'hC7
`define TWUG_ADDR_CHIP 8'h9F
`define TWUG_ADDR_PROG 8'hA4
`define TWUG_ADDR_PMON 8'hAC
`define TWUG_ADDR_SHAD 8'h9C
`define TWUG_ADDR_WDOG 8'hAA

// Key values
`define TWUG_KEY_FIRST 8'hAA
`define TWUG_KEY_SECOND 8'h55

// Reset values
`define TWUG_KEY_RST 8'h00
`define TWUG_PROT_RST 8'h00
`define TWUG_RDATA_RST 8'h00

// Timing in machine cycles
`define TWUG_KEY_WAIT_MC 2'd3
`define TWUG_WINDOW_MC 2'd3
`define TWUG_CNT_ZERO 2'd0
`define TWUG_CNT_ONE 2'd1

`endif

/* twug_pkg.sv */
package twug_pkg;

  typedef logic [7:0] twug_byte_t;
  typedef logic [1:0] twug_cnt_t;

  typedef enum logic [2:0]
  {
    TWUG_SEL_NONE,
    TWUG_SEL_KEY,
    TWUG_SEL_CHIP,
    TWUG_SEL_PROG,
    TWUG_SEL_PMON,
    TWUG_SEL_SHAD,
    TWUG_SEL_WDOG
  } twug_sel_t;

endpackage : twug_pkg

/* twug_timed_write_unlock_guard.sv */
// What this block does
// - A first key write starts a three machine cycle wait for the second key.
// - Second key within the wait opens the window; a late one leaves it shut.
// - The open window lasts three machine cycles and closes by itself.
// - Protected writes land only while the window is open; others are dropped.
// - Several protected writes may land in one window; later ones fail.
// - Reads of protected registers are never blocked.
// - Five registers are protected: chip, program trigger, power, shadow, watchdog.
// - Key register resets to zero and the window starts closed.
`timescale 1ns/1ns
`include "twug_consts.svh"

module twug_timed_write_unlock_guard
  import twug_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Machine cycle strobe from the core
  input wire logic mc_strobe_i,
  // Special-function register access from the core
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire twug_byte_t sfr_addr_i,
  input wire twug_byte_t sfr_wdata_i,
  output twug_byte_t sfr_rdata_o,
  // Register contents towards the rest of the chip
  output twug_byte_t timed_access_key_o,
  output twug_byte_t chip_control_reg_o,
  output twug_byte_t program_trigger_reg_o,
  output twug_byte_t power_monitor_control_reg_o,
  output twug_byte_t shadow_reg_9c_o,
  output twug_byte_t watchdog_control_reg_o,
  // Window state
  output logic window_open_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic twug_sel_t twug_decode(input twug_byte_t addr);
    twug_sel_t sel;
    sel = TWUG_SEL_NONE;
    case (addr)
      `TWUG_ADDR_KEY: sel = TWUG_SEL_KEY;
      `TWUG_ADDR_CHIP: sel = TWUG_SEL_CHIP;
      `TWUG_ADDR_PROG: sel = TWUG_SEL_PROG;
      `TWUG_ADDR_PMON: sel = TWUG_SEL_PMON;
      `TWUG_ADDR_SHAD: sel = TWUG_SEL_SHAD;
      `TWUG_ADDR_WDOG: sel = TWUG_SEL_WDOG;
      default: sel = TWUG_SEL_NONE;
    endcase
    return sel;
  endfunction : twug_decode

  twug_sel_t wr_sel;
  twug_sel_t rd_sel;
  logic key_wr;
  logic first_key;
  logic second_key;

  assign wr_sel = twug_decode(sfr_addr_i);
  assign rd_sel = twug_decode(sfr_addr_i);
  assign key_wr = sfr_wr_i && (wr_sel == TWUG_SEL_KEY);
  assign first_key = key_wr && (sfr_wdata_i == `TWUG_KEY_FIRST);
  assign second_key = key_wr && (sfr_wdata_i == `TWUG_KEY_SECOND);

  ////////////////////////////////////////////////////////////////////////////////
  // Key wait and window counters

  twug_cnt_t wait_cnt_ff;
  twug_cnt_t nxt_wait_cnt;
  twug_cnt_t win_cnt_ff;
  twug_cnt_t nxt_win_cnt;
  logic win_active;

  assign win_active = (win_cnt_ff != `TWUG_CNT_ZERO);

  always_comb
  begin
    nxt_wait_cnt = wait_cnt_ff;
    nxt_win_cnt = win_cnt_ff;
    if (mc_strobe_i && (wait_cnt_ff != `TWUG_CNT_ZERO))
    begin
      nxt_wait_cnt = wait_cnt_ff - `TWUG_CNT_ONE;
    end
    if (mc_strobe_i && win_active)
    begin
      nxt_win_cnt = win_cnt_ff - `TWUG_CNT_ONE;
    end
    if (key_wr)
    begin
      // any key write other than the first key ends the wait
      nxt_wait_cnt = `TWUG_CNT_ZERO;
      if (first_key)
      begin
        nxt_wait_cnt = `TWUG_KEY_WAIT_MC;
      end
      if (second_key && (wait_cnt_ff != `TWUG_CNT_ZERO))
      begin
        nxt_win_cnt = `TWUG_WINDOW_MC;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      wait_cnt_ff <= `TWUG_CNT_ZERO;
      win_cnt_ff <= `TWUG_CNT_ZERO;
    end
    else
    begin
      wait_cnt_ff <= nxt_wait_cnt;
      win_cnt_ff <= nxt_win_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Key and protected registers

  twug_byte_t key_ff, nxt_key;
  twug_byte_t chip_ff, nxt_chip;
  twug_byte_t prog_ff, nxt_prog;
  twug_byte_t pmon_ff, nxt_pmon;
  twug_byte_t shad_ff, nxt_shad;
  twug_byte_t wdog_ff, nxt_wdog;
  logic prot_wr;
  logic win_ff, nxt_win;

  assign prot_wr = sfr_wr_i && win_active;

  always_comb
  begin
    nxt_key = key_ff;
    nxt_chip = chip_ff;
    nxt_prog = prog_ff;
    nxt_pmon = pmon_ff;
    nxt_shad = shad_ff;
    nxt_wdog = wdog_ff;
    if (key_wr)
    begin
      nxt_key = sfr_wdata_i;
    end
    if (prot_wr)
    begin
      case (wr_sel)
        TWUG_SEL_CHIP: nxt_chip = sfr_wdata_i;
        TWUG_SEL_PROG: nxt_prog = sfr_wdata_i;
        TWUG_SEL_PMON: nxt_pmon = sfr_wdata_i;
        TWUG_SEL_SHAD: nxt_shad = sfr_wdata_i;
        TWUG_SEL_WDOG: nxt_wdog = sfr_wdata_i;
        default: nxt_chip = chip_ff;
      endcase
    end
    nxt_win = (nxt_win_cnt != `TWUG_CNT_ZERO);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      key_ff <= `TWUG_KEY_RST;
      chip_ff <= `TWUG_PROT_RST;
      prog_ff <= `TWUG_PROT_RST;
      pmon_ff <= `TWUG_PROT_RST;
      shad_ff <= `TWUG_PROT_RST;
      wdog_ff <= `TWUG_PROT_RST;
      win_ff <= 1'b0;
    end
    else
    begin
      key_ff <= nxt_key;
      chip_ff <= nxt_chip;
      prog_ff <= nxt_prog;
      pmon_ff <= nxt_pmon;
      shad_ff <= nxt_shad;
      wdog_ff <= nxt_wdog;
      win_ff <= nxt_win;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  twug_byte_t rdata_ff, nxt_rdata;

  always_comb
  begin
    nxt_rdata = `TWUG_RDATA_RST;
    if (sfr_rd_i)
    begin
      case (rd_sel)
        TWUG_SEL_KEY: nxt_rdata = key_ff;
        TWUG_SEL_CHIP: nxt_rdata = chip_ff;
        TWUG_SEL_PROG: nxt_rdata = prog_ff;
        TWUG_SEL_PMON: nxt_rdata = pmon_ff;
        TWUG_SEL_SHAD: nxt_rdata = shad_ff;
        TWUG_SEL_WDOG: nxt_rdata = wdog_ff;
        default: nxt_rdata = `TWUG_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rdata_ff <= `TWUG_RDATA_RST;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata_o = rdata_ff;
  assign timed_access_key_o = key_ff;
  assign chip_control_reg_o = chip_ff;
  assign program_trigger_reg_o = prog_ff;
  assign power_monitor_control_reg_o = pmon_ff;
  assign shadow_reg_9c_o = shad_ff;
  assign watchdog_control_reg_o = wdog_ff;
  assign window_open_o = win_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_unlock;
    first_key ##1 (!key_wr && wait_cnt_ff == 2'd3);
  endsequence

  property p_key_start;
    @(posedge core_clk_i) disable iff (reset_i)
    (first_key && !reset_i) |-> s_unlock or (first_key ##1 wait_cnt_ff == 2'd3);
  endproperty
  a_key_start: assert property (p_key_start) else $error("wait not started");

  property p_open;
    @(posedge core_clk_i) disable iff (reset_i)
    (second_key && wait_cnt_ff != 2'd0) |=> (win_cnt_ff == 2'd3) && window_open_o;
  endproperty
  a_open: assert property (p_open) else $error("window not opened");

  property p_late;
    @(posedge core_clk_i) disable iff (reset_i)
    (second_key && wait_cnt_ff == 2'd0 && win_cnt_ff == 2'd0) |=> !window_open_o;
  endproperty
  a_late: assert property (p_late) else $error("late key opened window");

  property p_close;
    @(posedge core_clk_i) disable iff (reset_i)
    (mc_strobe_i && win_active && !second_key) |=> win_cnt_ff == $past(win_cnt_ff) - 2'd1;
  endproperty
  a_close: assert property (p_close) else $error("window did not count down");

  property p_discard;
    @(posedge core_clk_i) disable iff (reset_i)
    (sfr_wr_i && sfr_addr_i == `TWUG_ADDR_CHIP && !win_active) |=> $stable(chip_control_reg_o);
  endproperty
  a_discard: assert property (p_discard) else $error("closed write landed");

  property p_accept;
    @(posedge core_clk_i) disable iff (reset_i)
    (sfr_wr_i && sfr_addr_i == `TWUG_ADDR_WDOG && win_active)
      |=> watchdog_control_reg_o == $past(sfr_wdata_i);
  endproperty
  a_accept: assert property (p_accept) else $error("open write lost");

  property p_read;
    @(posedge core_clk_i) disable iff (reset_i)
    (sfr_rd_i && sfr_addr_i == `TWUG_ADDR_PMON) |=> sfr_rdata_o == $past(pmon_ff);
  endproperty
  a_read: assert property (p_read) else $error("read blocked");

  property p_reset;
    @(posedge core_clk_i)
    reset_i |=> (timed_access_key_o == 8'h00) && !window_open_o;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");

  property p_stray;
    @(posedge core_clk_i) disable iff (reset_i)
    (key_wr && !first_key) |=> wait_cnt_ff == 2'd0;
  endproperty
  a_stray: assert property (p_stray) else $error("stray key kept wait");

endmodule : twug_timed_write_unlock_guard

/* twug_core_model.sv */
`timescale 1ns/1ns
module twug_core_model
  import twug_pkg::*;
#(
  parameter int MC_CLKS = 4
)
(
  // Clock
  input wire logic core_clk_i,
  // Core side of the register bus
  output logic mc_strobe_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output twug_byte_t sfr_addr_o,
  output twug_byte_t sfr_wdata_o,
  input wire twug_byte_t sfr_rdata_i
);
  int mc_cnt = 0;
  initial
  begin
    mc_strobe_o = 1'b0;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
  end
  // One strobe every MC_CLKS clocks
  always @(posedge core_clk_i)
  begin
    #1;
    mc_cnt = (mc_cnt + 1) % MC_CLKS;
    mc_strobe_o = (mc_cnt == MC_CLKS - 1);
  end
  task automatic sync_mc();
    @(posedge core_clk_i);
    while (mc_strobe_o !== 1'b1)
      @(posedge core_clk_i);
  endtask : sync_mc
  task automatic idle_mc(input int n);
    repeat (n) sync_mc();
  endtask : idle_mc
  task automatic access(input logic wr, input twug_byte_t a, input twug_byte_t d,
                        output twug_byte_t q);
    sync_mc();
    #1;
    sfr_wr_o = wr;
    sfr_rd_o = !wr;
    sfr_addr_o = a;
    sfr_wdata_o = d;
    @(posedge core_clk_i);
    #1;
    q = sfr_rdata_i;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_addr_o = ~a;
    sfr_wdata_o = ~d;
  endtask : access
endmodule : twug_core_model

/* twug_timed_write_unlock_guard_tb.sv */
`timescale 1ns/1ns
`include "twug_consts.svh"
module twug_timed_write_unlock_guard_tb
  import twug_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic stb, wr_s, rd_s, win;
  twug_byte_t addr, wdat, rdat, key, r0, r1, r2, r3, r4;
  twug_byte_t pa [5] = '{`TWUG_ADDR_CHIP, `TWUG_ADDR_PROG, `TWUG_ADDR_PMON,
                         `TWUG_ADDR_SHAD, `TWUG_ADDR_WDOG};
  int failures = 0;
  int check_count = 0;
  always #20 core_clk_i = ~core_clk_i;
  twug_core_model core_inst (.core_clk_i(core_clk_i), .mc_strobe_o(stb), .sfr_wr_o(wr_s),
    .sfr_rd_o(rd_s), .sfr_addr_o(addr), .sfr_wdata_o(wdat), .sfr_rdata_i(rdat));
  twug_timed_write_unlock_guard twug_timed_write_unlock_guard_inst (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .mc_strobe_i(stb), .sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_addr_i(addr),
    .sfr_wdata_i(wdat), .sfr_rdata_o(rdat), .timed_access_key_o(key),
    .chip_control_reg_o(r0), .program_trigger_reg_o(r1), .power_monitor_control_reg_o(r2),
    .shadow_reg_9c_o(r3), .watchdog_control_reg_o(r4), .window_open_o(win));
  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic twug_byte_t po(input int i);
    case (i)
      0: return r0;
      1: return r1;
      2: return r2;
      3: return r3;
      default: return r4;
    endcase
  endfunction : po
  task automatic chk(input string n, input twug_byte_t s, input twug_byte_t e);
    check_count++;
    if (s !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, s);
      failures++;
    end
  endtask : chk
  task automatic wr(input twug_byte_t a, input twug_byte_t d);
    twug_byte_t q;
    core_inst.access(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string n, input twug_byte_t a, input twug_byte_t e);
    twug_byte_t q;
    core_inst.access(1'b0, a, 8'h00, q);
    chk(n, q, e);
  endtask : rd_chk
  task automatic unlock(input int gap);
    wr(`TWUG_ADDR_KEY, `TWUG_KEY_FIRST);
    core_inst.idle_mc(gap);
    wr(`TWUG_ADDR_KEY, `TWUG_KEY_SECOND);
  endtask : unlock
  task automatic t_reset();
    chk("window", {7'h00, win}, 8'h00);
    rd_chk("key", `TWUG_ADDR_KEY, `TWUG_KEY_RST);
    for (int i = 0; i < 5; i++)
      rd_chk("prot_rst", pa[i], `TWUG_PROT_RST);
  endtask : t_reset
  task automatic t_locked();
    for (int i = 0; i < 5; i++)
    begin
      wr(pa[i], 8'h3C);
      chk("locked", po(i), 8'h00);
    end
    wr(`TWUG_ADDR_KEY, 8'h5A);
    wr(`TWUG_ADDR_KEY, `TWUG_KEY_SECOND);
    chk("stray_key", {7'h00, win}, 8'h00);
  endtask : t_locked
  task automatic t_each();
    for (int i = 0; i < 5; i++)
    begin
      unlock(0);
      wr(pa[i], twug_byte_t'(8'hA0 + i));
      chk("open", {7'h00, win}, 8'h01);
      chk("prot_out", po(i), twug_byte_t'(8'hA0 + i));
      core_inst.idle_mc(3);
      rd_chk("readback", pa[i], twug_byte_t'(8'hA0 + i));
    end
  endtask : t_each
  task automatic t_wait();
    unlock(1);
    wr(pa[0], 8'h61);
    chk("wait_ok", r0, 8'h61);
    core_inst.idle_mc(3);
    unlock(2);
    chk("late_win", {7'h00, win}, 8'h00);
    wr(pa[1], 8'h62);
    chk("late_wr", r1, 8'hA1);
  endtask : t_wait
  task automatic t_multi();
    unlock(0);
    wr(pa[2], 8'h11);
    wr(pa[3], 8'h22);
    wr(pa[4], 8'h33);
    chk("multi_a", r2, 8'h11);
    chk("multi_b", r3, 8'h22);
    chk("multi_c", r4, 8'hA4);
    chk("closed", {7'h00, win}, 8'h00);
    wr(`TWUG_ADDR_KEY, `TWUG_KEY_SECOND);
    wr(pa[2], 8'h44);
    chk("repeat", r2, 8'h11);
    chk("key_out", key, `TWUG_KEY_SECOND);
    rd_chk("key_rd", `TWUG_ADDR_KEY, `TWUG_KEY_SECOND);
    @(posedge core_clk_i);
    #1;
    chk("rd_idle", rdat, `TWUG_RDATA_RST);
    rd_chk("unmapped", 8'hC6, `TWUG_RDATA_RST);
  endtask : t_multi
  task automatic t_rst_open();
    unlock(0);
    wr(pa[2], 8'h66);
    chk("pre_rst", r2, 8'h66);
    reset_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    chk("rst_win", {7'h00, win}, 8'h00);
    chk("rst_key", key, `TWUG_KEY_RST);
    chk("rst_prot", r2, `TWUG_PROT_RST);
    wr(pa[2], 8'h77);
    chk("rst_locked", r2, `TWUG_PROT_RST);
  endtask : t_rst_open
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    #(40 * 5000);
    failures++;
    test_done();
  end
  initial
  begin
    repeat (2) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    t_locked();
    t_each();
    t_wait();
    t_multi();
    t_rst_open();
    test_done();
  end
endmodule : twug_timed_write_unlock_guard_tb
